// >>> hw/din_func_pkg.sv
// Package for the terminal-block input function decoder.
// Assumes a single 200 MHz clock domain and synchronous inputs.
package din_func_pkg;
   localparam int unsigned NUM_IN        = 6;
   localparam int unsigned SEL_W         = 5;
   localparam int unsigned POT_W         = 16;
   localparam int unsigned RATE_W        = 16;
   localparam int unsigned LVL_W         = 12;
   localparam int unsigned MODE_W        = 3;
   localparam int unsigned SRC_W         = 4;
   // Input function codes for each physical input's selector
   localparam logic [4:0] FN_UNUSED      = 5'h00;
   localparam logic [4:0] FN_ACC_DEC2    = 5'h01;
   localparam logic [4:0] FN_POT_UP      = 5'h02;
   localparam logic [4:0] FN_POT_DOWN    = 5'h03;
   localparam logic [4:0] FN_STOP_B      = 5'h04;
   localparam logic [4:0] FN_BUSREG_B    = 5'h05;
   localparam logic [4:0] FN_LOOP_RUN    = 5'h06;
   localparam logic [4:0] FN_INT_FREEZE  = 5'h07;
   localparam logic [4:0] FN_INT_ZERO    = 5'h08;
   localparam logic [4:0] FN_AUX_FAULT   = 5'h09;
   localparam logic [4:0] FN_LOCAL       = 5'h0A;
   localparam logic [4:0] FN_CLR_FAULT   = 5'h0B;
   localparam logic [4:0] FN_ENABLE      = 5'h0C;
   localparam logic [4:0] FN_LINK_ONLY   = 5'h0D;
   localparam logic [4:0] FN_PL_LEVEL    = 5'h0E;
   localparam logic [4:0] FN_PRECHARGE   = 5'h0F;
   localparam logic [4:0] FN_STOP_CLR    = 5'h10;
   // Reference source code meaning "motor pot"
   localparam logic [3:0] SRC_POT        = 4'h1;
   // Terminal block bit position in the owner masks
   localparam int unsigned TB_BIT        = 1;
   localparam int unsigned MASK_W        = 8;
   // Pot ramp: rate is 1 Hz/s, setpoint is 0.01 Hz; one step per 10 ms
   localparam int unsigned STEP_MS       = 10;
   localparam int unsigned CLK_MHZ       = 200;
   localparam int unsigned STEP_CYC      = STEP_MS * CLK_MHZ * 1000;
   localparam logic [POT_W-1:0] POT_MAX  = 16'hFFFF;
   // Internal power-loss level: 82 percent of nominal, in percent units
   localparam logic [LVL_W-1:0] PL_INTERNAL = 12'h052;
   localparam logic [POT_W-1:0] POT_RST  = 16'h0000;
endpackage

// >>> hw/pot_ramp.sv
// Motor pot setpoint ramp with retained value.
// Assumes the nonvolatile store restores nv_value before rst_n releases.
`timescale 1ns/10ps
module pot_ramp
   import din_func_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Control
   input  wire logic                  step_en,
   input  wire logic                  up,
   input  wire logic                  down,
   input  wire logic [RATE_W-1:0]     pot_ramp_rate,
   // Retained value
   input  wire logic [POT_W-1:0]      nv_value,
   input  wire logic                  nv_load,
   output logic      [POT_W-1:0]      motor_pot_setpoint
);
   typedef struct packed {
      logic [POT_W-1:0] val;
   } pot_state_t;

   pot_state_t st_ff;
   pot_state_t nxt_st;
   logic [POT_W:0] sum;

   always_comb begin
      nxt_st = st_ff;
      sum    = '0;
      if (nv_load) begin
         nxt_st.val = nv_value;
      end else if (step_en && up && !down) begin
         sum = {1'b0, st_ff.val} + {1'b0, pot_ramp_rate};
         nxt_st.val = sum[POT_W] ? POT_MAX : sum[POT_W-1:0];
      end else if (step_en && down && !up) begin
         nxt_st.val = (st_ff.val > pot_ramp_rate) ? st_ff.val - pot_ramp_rate : '0;
      end
      // Both closed: value unchanged
   end

   always_ff @(posedge clk) begin
      if (!rst_n) st_ff <= '{val: POT_RST};
      else        st_ff <= nxt_st;
   end

   assign motor_pot_setpoint = st_ff.val;
endmodule

// >>> hw/din_func.sv
// Terminal-block digital input function decoder for a drive control core.
// Assumes inputs already debounced and synchronous to clk.
// What this block does
// - Rate input picks time set 1 or 2
// - Rate select needs accel and logic masks
// - Up input raises pot at ramp rate
// - Down input lowers pot at ramp rate
// - Both up and down hold pot
// - Pot setpoint kept in nonvolatile storage
// - Pot inputs need pot and logic masks
// - Pot is reference only if selected
// - Stop mode B when input closed
// - Bus regulation B when input closed
// - PI loop runs while enable closed
// - Freeze input holds integrator
// - Zero input clears integrator
// - Assigned aux fault open trips always
// - Local gives terminal exclusive control, stops honoured
// - Local control granted only when stopped
// - Local ownership needs free owner, masks
// - Clear input rising edge resets fault
// - Dedicated clear wins; needs fault masks
// - All enables closed to run, else coast
// - Output link follows input unless unused
// - Level input picks parameter power-loss level
// - Precharge open: relay open, coast stop
`timescale 1ns/10ps
module din_func
   import din_func_pkg::*;
(
   // Clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  rst_n,
   // Terminal inputs and their function selectors
   input  wire logic [din_func_pkg::NUM_IN-1:0]       din,
   input  wire logic [din_func_pkg::SEL_W-1:0]        din_sel [din_func_pkg::NUM_IN],
   // Output link selectors: bit n set means output follows input n
   input  wire logic [din_func_pkg::NUM_IN-1:0]       dout_link_sel [2],
   // Owner masks
   input  wire logic [din_func_pkg::MASK_W-1:0]       logic_mask,
   input  wire logic [din_func_pkg::MASK_W-1:0]       accel_mask,
   input  wire logic [din_func_pkg::MASK_W-1:0]       pot_owner_mask,
   input  wire logic [din_func_pkg::MASK_W-1:0]       local_mask,
   input  wire logic [din_func_pkg::MASK_W-1:0]       fault_mask,
   input  wire logic                                  other_local_owner,
   // Parameters from the control core
   input  wire logic [din_func_pkg::RATE_W-1:0]       pot_ramp_rate,
   input  wire logic [din_func_pkg::RATE_W-1:0]       accel_time1,
   input  wire logic [din_func_pkg::RATE_W-1:0]       accel_time2,
   input  wire logic [din_func_pkg::RATE_W-1:0]       decel_time1,
   input  wire logic [din_func_pkg::RATE_W-1:0]       decel_time2,
   input  wire logic [din_func_pkg::SRC_W-1:0]        ref_a_src,
   input  wire logic [din_func_pkg::SRC_W-1:0]        ref_b_src,
   input  wire logic [din_func_pkg::MODE_W-1:0]       stop_mode_a,
   input  wire logic [din_func_pkg::MODE_W-1:0]       stop_mode_b,
   input  wire logic [din_func_pkg::MODE_W-1:0]       busreg_mode_a,
   input  wire logic [din_func_pkg::MODE_W-1:0]       busreg_mode_b,
   input  wire logic [din_func_pkg::LVL_W-1:0]        pl_level_param,
   // Drive state
   input  wire logic                                  drive_running,
   input  wire logic                                  fault_active,
   input  wire logic                                  any_stop_req,
   input  wire logic [din_func_pkg::POT_W-1:0]        nv_pot_value,
   input  wire logic                                  nv_pot_load,
   // Rate and reference outputs
   output logic                                       tb_rate_owner,
   output logic [din_func_pkg::RATE_W-1:0]            accel_time,
   output logic [din_func_pkg::RATE_W-1:0]            decel_time,
   output logic [din_func_pkg::POT_W-1:0]             motor_pot_setpoint,
   output logic                                       pot_is_ref,
   // Mode outputs
   output logic [din_func_pkg::MODE_W-1:0]            stop_mode,
   output logic [din_func_pkg::MODE_W-1:0]            busreg_mode,
   // Process loop controls
   output logic                                       loop_enable,
   output logic                                       integ_hold,
   output logic                                       integ_zero,
   // Fault, ownership and run control
   output logic                                       aux_fault_trip,
   output logic                                       fault_reset,
   output logic                                       tb_local_owner,
   output logic                                       network_lockout,
   output logic                                       stop_honoured,
   output logic                                       start_permit,
   output logic                                       coast_stop,
   output logic                                       not_enabled,
   // Power section
   output logic [din_func_pkg::LVL_W-1:0]             pl_level,
   output logic                                       precharge_relay_open,
   output logic                                       precharge_state,
   // Pass-through outputs
   output logic [1:0]                                 dout_link
);
   import din_func_pkg::*;

   typedef struct packed {
      logic [31:0]         step_cnt;
      logic                step_en;
      logic                clr_prev;
      logic                tb_rate_owner;
      logic [RATE_W-1:0]   accel_time;
      logic [RATE_W-1:0]   decel_time;
      logic                pot_is_ref;
      logic [MODE_W-1:0]   stop_mode;
      logic [MODE_W-1:0]   busreg_mode;
      logic                loop_enable;
      logic                integ_hold;
      logic                integ_zero;
      logic                aux_fault_trip;
      logic                fault_reset;
      logic                tb_local_owner;
      logic                network_lockout;
      logic                stop_honoured;
      logic                start_permit;
      logic                coast_stop;
      logic                not_enabled;
      logic [LVL_W-1:0]    pl_level;
      logic                precharge_relay_open;
      logic                precharge_state;
      logic [1:0]          dout_link;
   } din_state_t;

   din_state_t st_ff;
   din_state_t nxt_st;

   // Assigned inputs for a function, as a bit mask over the inputs
   function automatic logic [NUM_IN-1:0] fn_map(input logic [4:0] fn);
      logic [NUM_IN-1:0] m;
      m = '0;
      for (int i = 0; i < NUM_IN; i++) m[i] = (din_sel[i] == fn);
      return m;
   endfunction

   function automatic logic tb_ok(input logic [MASK_W-1:0] m);
      return m[TB_BIT] && logic_mask[TB_BIT];
   endfunction

   logic [NUM_IN-1:0] m_acc, m_up, m_dn, m_stp, m_bus, m_run, m_frz, m_zro;
   logic [NUM_IN-1:0] m_aux, m_loc, m_clr, m_ena, m_pl, m_pre, m_sclr, m_unused;
   logic              pot_en;
   logic              clr_now;

   always_comb begin
      m_acc    = fn_map(FN_ACC_DEC2);
      m_up     = fn_map(FN_POT_UP);
      m_dn     = fn_map(FN_POT_DOWN);
      m_stp    = fn_map(FN_STOP_B);
      m_bus    = fn_map(FN_BUSREG_B);
      m_run    = fn_map(FN_LOOP_RUN);
      m_frz    = fn_map(FN_INT_FREEZE);
      m_zro    = fn_map(FN_INT_ZERO);
      m_aux    = fn_map(FN_AUX_FAULT);
      m_loc    = fn_map(FN_LOCAL);
      m_clr    = fn_map(FN_CLR_FAULT);
      m_ena    = fn_map(FN_ENABLE);
      m_pl     = fn_map(FN_PL_LEVEL);
      m_pre    = fn_map(FN_PRECHARGE);
      m_sclr   = fn_map(FN_STOP_CLR);
      m_unused = fn_map(FN_UNUSED);
   end

   assign pot_en = tb_ok(pot_owner_mask);

   pot_ramp u_pot (
      .clk                (clk),
      .rst_n              (rst_n),
      .step_en            (st_ff.step_en),
      .up                 (pot_en && |(din & m_up)),
      .down               (pot_en && |(din & m_dn)),
      .pot_ramp_rate      (pot_ramp_rate),
      .nv_value           (nv_pot_value),
      .nv_load            (nv_pot_load),
      .motor_pot_setpoint (motor_pot_setpoint)
   );

   always_comb begin
      nxt_st = st_ff;
      // Ramp tick divider: one step per fixed interval keeps rate in Hz/s
      if (st_ff.step_cnt == 32'(STEP_CYC - 1)) begin
         nxt_st.step_cnt = '0;
         nxt_st.step_en  = 1'b1;
      end else begin
         nxt_st.step_cnt = st_ff.step_cnt + 32'h0000_0001;
         nxt_st.step_en  = 1'b0;
      end

      nxt_st.tb_rate_owner = tb_ok(accel_mask) && (|m_acc);
      if (nxt_st.tb_rate_owner && |(din & m_acc)) begin
         nxt_st.accel_time = accel_time2;
         nxt_st.decel_time = decel_time2;
      end else begin
         nxt_st.accel_time = accel_time1;
         nxt_st.decel_time = decel_time1;
      end

      nxt_st.pot_is_ref  = (ref_a_src == SRC_POT) || (ref_b_src == SRC_POT);
      nxt_st.stop_mode   = |(din & m_stp) ? stop_mode_b : stop_mode_a;
      nxt_st.busreg_mode = |(din & m_bus) ? busreg_mode_b : busreg_mode_a;
      nxt_st.loop_enable = |(din & m_run);
      nxt_st.integ_hold  = |(din & m_frz);
      nxt_st.integ_zero  = |(din & m_zro);

      // Open assigned contact trips; no mask or owner gates it
      nxt_st.aux_fault_trip = |(~din & m_aux);

      // Ownership taken only while stopped and not held elsewhere
      if (!(|(din & m_loc)) || !tb_ok(local_mask)) begin
         nxt_st.tb_local_owner = 1'b0;
      end else if (!st_ff.tb_local_owner && !other_local_owner && !drive_running) begin
         nxt_st.tb_local_owner = 1'b1;
      end
      nxt_st.network_lockout = nxt_st.tb_local_owner;
      nxt_st.stop_honoured   = any_stop_req;

      // Edge on dedicated clear; combined input only when no dedicated one
      clr_now = (|m_clr) ? |(din & m_clr) : |(din & m_sclr);
      nxt_st.clr_prev    = clr_now;
      nxt_st.fault_reset = clr_now && !st_ff.clr_prev && fault_active
                           && tb_ok(fault_mask);

      // Every assigned enable and precharge contact must be closed
      nxt_st.start_permit = ((din & m_ena) == m_ena) && ((din & m_pre) == m_pre);
      nxt_st.not_enabled  = (din & m_ena) != m_ena;
      nxt_st.precharge_relay_open = (din & m_pre) != m_pre;
      nxt_st.precharge_state      = nxt_st.precharge_relay_open;
      nxt_st.coast_stop = drive_running && (nxt_st.not_enabled
                          || nxt_st.precharge_relay_open);

      nxt_st.pl_level = |(din & m_pl) ? pl_level_param : PL_INTERNAL;

      for (int k = 0; k < 2; k++) begin
         nxt_st.dout_link[k] = |(din & ~m_unused & dout_link_sel[k]);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.pl_level <= PL_INTERNAL;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tb_rate_owner        = st_ff.tb_rate_owner;
   assign accel_time           = st_ff.accel_time;
   assign decel_time           = st_ff.decel_time;
   assign pot_is_ref           = st_ff.pot_is_ref;
   assign stop_mode            = st_ff.stop_mode;
   assign busreg_mode          = st_ff.busreg_mode;
   assign loop_enable          = st_ff.loop_enable;
   assign integ_hold           = st_ff.integ_hold;
   assign integ_zero           = st_ff.integ_zero;
   assign aux_fault_trip       = st_ff.aux_fault_trip;
   assign fault_reset          = st_ff.fault_reset;
   assign tb_local_owner       = st_ff.tb_local_owner;
   assign network_lockout      = st_ff.network_lockout;
   assign stop_honoured        = st_ff.stop_honoured;
   assign start_permit         = st_ff.start_permit;
   assign coast_stop           = st_ff.coast_stop;
   assign not_enabled          = st_ff.not_enabled;
   assign pl_level             = st_ff.pl_level;
   assign precharge_relay_open = st_ff.precharge_relay_open;
   assign precharge_state      = st_ff.precharge_state;
   assign dout_link            = st_ff.dout_link;
endmodule

// >>> sim/din_func_checker.sv
// Concurrent checks on the input function decoder ports.
// Assumes registered outputs that follow sampled inputs one clock later.
`timescale 1ns/10ps
module din_func_checker
   import din_func_pkg::*;
(
   // Clock, reset and inputs
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [NUM_IN-1:0] din,
   input  wire logic [SEL_W-1:0]  din_sel [NUM_IN],
   input  wire logic [MASK_W-1:0] logic_mask,
   input  wire logic [MASK_W-1:0] fault_mask,
   input  wire logic [MODE_W-1:0] stop_mode_a,
   input  wire logic [MODE_W-1:0] stop_mode_b,
   input  wire logic [LVL_W-1:0]  pl_level_param,
   input  wire logic              drive_running,
   input  wire logic              fault_active,
   // Watched outputs
   input  wire logic [MODE_W-1:0] stop_mode,
   input  wire logic              loop_enable,
   input  wire logic              integ_hold,
   input  wire logic              integ_zero,
   input  wire logic              aux_fault_trip,
   input  wire logic              fault_reset,
   input  wire logic              coast_stop,
   input  wire logic              not_enabled,
   input  wire logic [LVL_W-1:0]  pl_level,
   input  wire logic              precharge_state
);
   import din_func_pkg::*;
   // Closed and open state gathered per function code
   logic [31:0] cls;
   logic [31:0] opn;
   always_comb begin
      cls = '0;
      opn = '0;
      for (int i = 0; i < NUM_IN; i++) begin
         cls[din_sel[i]] |= din[i];
         opn[din_sel[i]] |= !din[i];
      end
   end
   default clocking dcb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence clr_rise;
      cls[FN_CLR_FAULT] && !$past(cls[FN_CLR_FAULT]) && fault_active && fault_mask[TB_BIT] && logic_mask[TB_BIT];
   endsequence
   stop_select_a: assert property ($past(rst_n) |->
      stop_mode == ($past(cls[FN_STOP_B]) ? $past(stop_mode_b) : $past(stop_mode_a))) else $error("stop mode wrong");
   loop_run_a: assert property ($past(rst_n) |-> loop_enable == $past(cls[FN_LOOP_RUN]))
      else $error("loop enable wrong");
   integ_ctl_a: assert property ($past(rst_n) |->
      {integ_hold, integ_zero} == {$past(cls[FN_INT_FREEZE]), $past(cls[FN_INT_ZERO])}) else $error("integrator ctl wrong");
   aux_trip_a: assert property ($past(rst_n) |-> aux_fault_trip == $past(opn[FN_AUX_FAULT]))
      else $error("aux fault wrong");
   clear_pulse_a: assert property (clr_rise |=> fault_reset ##1 !fault_reset)
      else $error("fault reset pulse missing");
   clear_mask_a: assert property (fault_reset |-> $past(fault_mask[TB_BIT]) && $past(logic_mask[TB_BIT]))
      else $error("fault reset without masks");
   enable_coast_a: assert property ($past(opn[FN_ENABLE]) && $past(drive_running) && $past(rst_n) |->
      coast_stop && not_enabled) else $error("enable drop not coasting");
   pl_select_a: assert property ($past(rst_n) |->
      pl_level == ($past(cls[FN_PL_LEVEL]) ? $past(pl_level_param) : PL_INTERNAL)) else $error("power loss level wrong");
   precharge_a: assert property ($past(opn[FN_PRECHARGE]) && $past(rst_n) |->
      precharge_state && (coast_stop || !$past(drive_running)))
      else $error("precharge open not handled");
endmodule
bind din_func din_func_checker chk (.*);

// >>> sim/contact_bank.sv
// Terminal-block switches and machine contacts feeding the decoder.
// Assumes the bench requests contact states; contacts are level and never float.
`timescale 1ns/10ps
module contact_bank
   import din_func_pkg::*;
(
   // Clock
   input  wire logic              clk,
   // Requested and actual contact states
   input  wire logic [NUM_IN-1:0] want,
   output logic      [NUM_IN-1:0] din
);
   // Contacts move off the sampling edge so the decoder never races them
   initial din = '0;
   always @(negedge clk) begin
      din <= want;
   end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the input function decoder.
// Assumes the contact model drives din and the checker binds itself to the decoder.
`timescale 1ns/10ps
module tb_top;
   import din_func_pkg::*;
   logic                clk, rst_n, nv_pot_load, other_local_owner, drive_running, fault_active, any_stop_req;
   logic [NUM_IN-1:0]   din, want;
   logic [SEL_W-1:0]    din_sel [NUM_IN];
   logic [NUM_IN-1:0]   dout_link_sel [2];
   logic [MASK_W-1:0]   logic_mask, accel_mask, pot_owner_mask, local_mask, fault_mask;
   logic [RATE_W-1:0]   pot_ramp_rate, accel_time1, accel_time2, decel_time1, decel_time2, accel_time, decel_time;
   logic [SRC_W-1:0]    ref_a_src, ref_b_src;
   logic [MODE_W-1:0]   stop_mode_a, stop_mode_b, busreg_mode_a, busreg_mode_b, stop_mode, busreg_mode;
   logic [LVL_W-1:0]    pl_level_param, pl_level;
   logic [POT_W-1:0]    nv_pot_value, motor_pot_setpoint;
   logic                tb_rate_owner, pot_is_ref, loop_enable, integ_hold, integ_zero, aux_fault_trip, fault_reset;
   logic                tb_local_owner, network_lockout, stop_honoured, start_permit, coast_stop, not_enabled;
   logic                precharge_relay_open, precharge_state;
   logic [1:0]          dout_link;
   int                  n_mismatch = 0;
   int                  n_tests = 0;
   din_func dut (.*);
   contact_bank contacts (.clk(clk), .want(want), .din(din));
   always #2.5 clk = ~clk;
   task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wt(int n);
      repeat (n) @(negedge clk);
   endtask
   // Contact changes need one falling edge to reach din, so settle over three
   task automatic defaults();
      want <= '0;
      din_sel = '{default: FN_UNUSED};
      dout_link_sel = '{default: '0};
      {logic_mask, accel_mask, pot_owner_mask, local_mask, fault_mask} = '0;
      {nv_pot_load, other_local_owner, drive_running, fault_active, any_stop_req} = '0;
      {accel_time1, accel_time2, decel_time1, decel_time2} = 64'h0011_0022_0033_0044;
      pot_ramp_rate = 16'h0064;
      nv_pot_value = 16'h1234;
      pl_level_param = 12'h0C8;
      {ref_a_src, ref_b_src} = 8'h22;
      {stop_mode_a, stop_mode_b, busreg_mode_a, busreg_mode_b} = {3'h1, 3'h6, 3'h2, 3'h5};
      wt(3);
   endtask
   task automatic t_rate();
      defaults();
      din_sel[0] = FN_ACC_DEC2;
      {accel_mask, logic_mask} = 16'h0202;
      wt(3);
      chk("accel open", 16'h0011, accel_time);
      want <= 6'h01;
      wt(3);
      chk("accel closed", 16'h0022, accel_time);
      chk("decel closed", 16'h0044, decel_time);
      chk("rate owner", 1'b1, tb_rate_owner);
      accel_mask = 8'hFD;
      wt(3);
      chk("rate owner masked", 1'b0, tb_rate_owner);
      $display("rate select test done");
   endtask
   task automatic t_pot();
      defaults();
      nv_pot_load = 1'b1;
      ref_b_src = SRC_POT;
      wt(1);
      nv_pot_load = 1'b0;
      din_sel[0] = FN_POT_UP;
      din_sel[1] = FN_POT_DOWN;
      {pot_owner_mask, logic_mask} = 16'h0202;
      want <= 6'h03;
      wt(4);
      chk("pot restored and held", 16'h1234, motor_pot_setpoint);
      chk("pot is ref", 1'b1, pot_is_ref);
      ref_b_src = 4'h2;
      wt(3);
      chk("pot not ref", 1'b0, pot_is_ref);
      $display("motor pot test done");
   endtask
   task automatic t_modes();
      logic b;
      defaults();
      din_sel = '{FN_INT_ZERO, FN_INT_FREEZE, FN_LOOP_RUN, FN_BUSREG_B, FN_STOP_B, FN_UNUSED};
      for (int k = 1; k >= 0; k--) begin
         b = k[0];
         want <= b ? 6'h1F : 6'h00;
         wt(3);
         chk("stop mode", b ? 16'h0006 : 16'h0001, stop_mode);
         chk("bus reg mode", b ? 16'h0005 : 16'h0002, busreg_mode);
         chk("loop enable", b, loop_enable);
         chk("integ hold", b, integ_hold);
         chk("integ zero", b, integ_zero);
      end
      want <= 6'h1F;
      din_sel[4] = FN_UNUSED;
      wt(3);
      chk("stop mode unassigned", 16'h0001, stop_mode);
      $display("mode select test done");
   endtask
   task automatic t_fault();
      defaults();
      din_sel[0] = FN_AUX_FAULT;
      wt(3);
      chk("aux open no masks", 1'b1, aux_fault_trip);
      din_sel[0] = FN_STOP_CLR;
      din_sel[1] = FN_CLR_FAULT;
      fault_active = 1'b1;
      {fault_mask, logic_mask} = 16'h0202;
      want <= 6'h01;
      wt(3);
      chk("aux unassigned", 1'b0, aux_fault_trip);
      chk("stop clear ignored", 1'b0, fault_reset);
      want <= 6'h03;
      wt(2);
      chk("clear pulse", 1'b1, fault_reset);
      wt(1);
      chk("clear pulse ends", 1'b0, fault_reset);
      want <= 6'h00;
      fault_mask = 8'hFD;
      wt(2);
      want <= 6'h02;
      wt(2);
      chk("clear masked", 1'b0, fault_reset);
      $display("fault test done");
   endtask
   task automatic t_run();
      defaults();
      din_sel[2] = FN_ENABLE;
      din_sel[3] = FN_PRECHARGE;
      din_sel[4] = FN_PL_LEVEL;
      want <= 6'h1C;
      wt(3);
      chk("permit", 1'b1, start_permit);
      chk("param level", 16'h00C8, pl_level);
      drive_running = 1'b1;
      want <= 6'h08;
      wt(3);
      chk("no permit", 1'b0, start_permit);
      chk("coast", 1'b1, coast_stop & not_enabled);
      chk("internal level", 16'h0052, pl_level);
      want <= 6'h04;
      wt(3);
      chk("relay open", 1'b1, precharge_relay_open & precharge_state & coast_stop);
      din_sel[3] = FN_UNUSED;
      wt(3);
      chk("bus assumed on", 1'b0, precharge_relay_open);
      $display("run control test done");
   endtask
   task automatic t_local();
      defaults();
      din_sel[5] = FN_LOCAL;
      {local_mask, logic_mask} = 16'h0202;
      drive_running = 1'b1;
      want <= 6'h20;
      wt(3);
      chk("local while running", 1'b0, tb_local_owner);
      drive_running = 1'b0;
      any_stop_req = 1'b1;
      wt(3);
      chk("local owner", 1'b1, tb_local_owner);
      chk("lockout and stop", 1'b1, network_lockout & stop_honoured);
      want <= 6'h00;
      other_local_owner = 1'b1;
      wt(3);
      want <= 6'h20;
      wt(3);
      chk("other owner", 1'b0, tb_local_owner);
      $display("local control test done");
   endtask
   task automatic t_link();
      defaults();
      din_sel[3] = FN_ENABLE;
      dout_link_sel[1] = 6'h08;
      want <= 6'h08;
      wt(3);
      chk("link follows", 16'h0002, dout_link);
      din_sel[3] = FN_UNUSED;
      wt(3);
      chk("link unused", 16'h0000, dout_link);
      $display("output link test done");
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      defaults();
      wt(7);
      rst_n = 1'b1;
      t_rate();
      t_pot();
      t_modes();
      t_fault();
      t_run();
      t_local();
      t_link();
      complete_run();
   end
   // Roughly 100 cycles of tests; twenty times that means a hang
   initial begin
      #10000;
      n_mismatch++;
      $display("[ERR] watchdog expected finish seen hang");
      complete_run();
   end
endmodule
